// >>> hw/sarcs_sequencer.sv
// Conversion sequencer of a 10-bit successive approximation converter.
// Assumes synchronous trigger inputs and a SAR core whose result is
// valid when the sequencer signals completion.
// Every output is taken straight from the state register.
//
// Design decisions made here: strobed register access and the register addresses.
module sarcs_sequencer (
  input wire logic core_clk,
  input wire logic rst,
  input wire sarcs_pkg::sarcs_bus_t bus,
  output logic [7:0] rdata,
  input wire logic [7:0] trig_in,
  input wire logic [9:0] sar_result,
  output sarcs_pkg::sarcs_analog_t analog,
  output logic conv_irq
);
  import sarcs_pkg::*;

  // Whole block state in one record. Timing runs in half conversion-clock
  // periods so the 1.5, 2.5 and 13.5 cycle sample points land on a core
  // clock edge; the price is a tick on both prescaler phases.
  typedef struct packed {
    logic enable;
    logic start_req;
    logic auto_trig;
    logic flag;
    logic irq_en;
    logic [2:0] psel;
    logic [2:0] tsel;
    logic power_reduce;
    logic ref_sw;
    logic left_adj;
    logic [3:0] chan_sw;
    logic ref_act;
    logic [3:0] chan_act;
    logic [9:0] result;
    logic lock;
    sarcs_state_t st;
    sarcs_kind_t kind;
    logic first;
    logic [6:0] pre_cnt;
    logic [5:0] half_cnt;
    logic [1:0] sync_cnt;
    logic trig_prev;
    logic [7:0] rdata;
    logic sample;
    logic irq;
    logic powered;
    logic busy;
  } sarcs_regs_t;

  sarcs_regs_t r;
  sarcs_regs_t next_r;

  // Derived combinational helpers
  // All of them read only registered state and the trigger inputs
  logic on;
  logic [7:0] div;
  logic tick_rise;
  logic tick_fall;
  logic tick_half;
  logic [5:0] half_end;
  logic [5:0] half_smp;
  logic [5:0] nh;
  logic trig_lvl;
  logic trig_edge;
  logic done;
  logic converting;
  logic [7:0] res_lo;
  logic [7:0] res_hi;

  // Prescaler rate: code 0 still divides by two
  // Limitation: division tops out at 128, so a fast core clock cannot
  // reach the slowest recommended conversion rates; software must
  // accept reduced resolution there.
  always_comb
  begin
    on = r.enable & ~r.power_reduce;
    if (r.psel == 3'h0)
      div = 8'h02;
    else
      div = 8'h01 << r.psel;
    tick_rise = on && ({1'b0, r.pre_cnt} == div - 8'h01);
    tick_fall = on && ({1'b0, r.pre_cnt} == (div >> 1) - 8'h01);
    tick_half = tick_rise | tick_fall;
  end

  // Per-kind timing of the running conversion
  // Ends compare against the next half count, so each end value is the
  // full length of that kind in half periods
  always_comb
  begin
    case (r.kind)
      SARCS_K_FIRST:
      begin
        half_end = HALF_END_FIRST;
        half_smp = HALF_SMP_FIRST;
      end
      SARCS_K_AUTO:
      begin
        half_end = HALF_END_AUTO;
        half_smp = HALF_SMP_AUTO;
      end
      SARCS_K_FREE:
      begin
        half_end = HALF_END_FREE;
        half_smp = HALF_SMP_FREE;
      end
      default:
      begin
        half_end = HALF_END_NORMAL;
        half_smp = HALF_SMP_NORMAL;
      end
    endcase
    nh = r.half_cnt + 6'h01;
    converting = (r.st == SARCS_ST_CONV);
    done = converting && tick_half && (nh == half_end);
  end

  // Trigger source and edge detection
  // Edge memory updates every cycle, also while busy, so a level that
  // stays high through a conversion never looks like a fresh edge and
  // the source must drop before it can start another run.
  always_comb
  begin
    trig_lvl = trig_in[r.tsel];
    trig_edge = trig_lvl & ~r.trig_prev;
  end

  // Result byte formatting
  // Unused bits of the justified byte read as zero
  always_comb
  begin
    if (r.left_adj)
    begin
      res_lo = {r.result[1:0], 6'h00};
      res_hi = r.result[9:2];
    end
    else
    begin
      res_lo = r.result[7:0];
      res_hi = {6'h00, r.result[9:8]};
    end
  end

  // Next-state logic for the whole block
  always_comb
  begin
    next_r = r;
    next_r.sample = 1'b0;
    next_r.trig_prev = trig_lvl;

    // Register writes
    if (bus.wr)
    begin
      case (bus.addr)
        REG_CTRL_A:
        begin
          next_r.enable = bus.wdata[CA_ENABLE];
          next_r.auto_trig = bus.wdata[CA_AUTO];
          next_r.irq_en = bus.wdata[CA_IRQ_EN];
          next_r.psel = bus.wdata[2:0];
          // Write one clears the flag
          if (bus.wdata[CA_FLAG])
            next_r.flag = 1'b0;
          // Start taken only when idle; a busy start already reads one
          if (bus.wdata[CA_START] && bus.wdata[CA_ENABLE] && on &&
              r.st == SARCS_ST_IDLE)
            next_r.start_req = 1'b1;
        end
        REG_CTRL_B:
          next_r.tsel = bus.wdata[2:0];
        REG_CHAN:
        begin
          // Software copies; the analog side sees them only via tracking
          next_r.ref_sw = bus.wdata[CH_REF];
          next_r.left_adj = bus.wdata[CH_LEFT];
          next_r.chan_sw = bus.wdata[3:0];
        end
        REG_POWER:
          next_r.power_reduce = bus.wdata[PW_REDUCE];
        default:
        begin
        end
      endcase
    end

    // Register reads, data stand one cycle later
    // Other cycles return zero so stale data never sits on the port
    next_r.rdata = 8'h00;
    if (bus.rd)
    begin
      case (bus.addr)
        REG_CTRL_A:
          next_r.rdata = {r.enable, r.start_req, r.auto_trig, r.flag,
                          r.irq_en, r.psel};
        REG_CTRL_B:
          next_r.rdata = {5'h00, r.tsel};
        REG_CHAN:
          next_r.rdata = {1'b0, r.ref_sw, r.left_adj, 1'b0, r.chan_sw};
        REG_RES_LO:
        begin
          // Low byte read freezes the pair until the high byte follows
          next_r.rdata = res_lo;
          next_r.lock = 1'b1;
        end
        REG_RES_HI:
        begin
          next_r.rdata = res_hi;
          next_r.lock = 1'b0;
        end
        REG_POWER:
          next_r.rdata = {7'h00, r.power_reduce};
        default:
          next_r.rdata = 8'h00;
      endcase
    end

    // Prescaler: free count while on, held at zero otherwise
    // Restart on each rising tick keeps both phases aligned
    if (!on)
      next_r.pre_cnt = 7'h00;
    else if (tick_rise)
      next_r.pre_cnt = 7'h00;
    else
      next_r.pre_cnt = r.pre_cnt + 7'h01;

    // Sequencer
    case (r.st)
      SARCS_ST_IDLE:
      begin
        // A software start on a rising tick wins over a trigger edge in the same cycle
        if (on && r.start_req && tick_rise)
        begin
          next_r.st = SARCS_ST_CONV;
          next_r.half_cnt = 6'h00;
          next_r.kind = r.first ? SARCS_K_FIRST : SARCS_K_NORMAL;
        end
        else if (on && r.auto_trig && r.tsel != TRIG_FREE && trig_edge)
        begin
          next_r.st = SARCS_ST_SYNC;
          next_r.sync_cnt = 2'h1;
          next_r.start_req = 1'b1;
        end
      end
      SARCS_ST_SYNC:
      begin
        // Extra core cycles before the prescaler restarts
        // Start already reads one while waiting
        if (r.sync_cnt == SYNC_CYCLES)
        begin
          next_r.st = SARCS_ST_CONV;
          next_r.pre_cnt = 7'h00;
          next_r.half_cnt = 6'h00;
          next_r.kind = r.first ? SARCS_K_FIRST : SARCS_K_AUTO;
        end
        else
          next_r.sync_cnt = r.sync_cnt + 2'h1;
      end
      SARCS_ST_CONV:
      begin
        // Trigger edges here fall through unused
        if (tick_half)
          next_r.half_cnt = nh;
        if (tick_half && nh == half_smp)
          next_r.sample = 1'b1;
        if (done)
        begin
          // A locked result pair drops this conversion
          if (!r.lock)
            next_r.result = sar_result;
          // Later runs use the short timing
          next_r.first = 1'b0;
          if (r.auto_trig && r.tsel == TRIG_FREE)
          begin
            // Restart at once whatever the flag shows
            next_r.half_cnt = 6'h00;
            next_r.kind = SARCS_K_FREE;
          end
          else
          begin
            next_r.st = SARCS_ST_IDLE;
            next_r.start_req = 1'b0;
          end
        end
      end
      default:
        next_r.st = SARCS_ST_IDLE;
    endcase

    // Completion sets the flag; set wins over a clear
    // The flag ignores the request enable, so it can act as a trigger
    if (done)
      next_r.flag = 1'b1;
    next_r.irq = next_r.flag & next_r.irq_en;

    // Selections follow software while on, except while a conversion holds them
    // Tracking resumes for the last conversion-clock cycle, two half ticks
    if (on && (!converting || r.half_cnt >= half_end - 6'h02))
    begin
      next_r.ref_act = r.ref_sw;
      next_r.chan_act = r.chan_sw;
    end

    // Disable aborts everything and rearms the long first conversion
    // Hazard: a start written with the enable is refused, since the old
    // enable is still low; software enables first, then starts
    if (!on)
    begin
      next_r.st = SARCS_ST_IDLE;
      next_r.start_req = 1'b0;
      next_r.first = 1'b1;
      next_r.half_cnt = 6'h00;
      next_r.sync_cnt = 2'h0;
    end

    // Registered copies for the analog side
    next_r.powered = next_r.enable & ~next_r.power_reduce;
    next_r.busy = (next_r.st == SARCS_ST_CONV);
  end

  // State register
  // Reset holds constants only; the first run after it is the long one
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      r <= '0;
      r.st <= SARCS_ST_IDLE;
      r.kind <= SARCS_K_NORMAL;
      r.first <= 1'b1;
    end
    else
      r <= next_r;
  end

  // Outputs straight from the state register
  always_comb
  begin
    rdata = r.rdata;
    conv_irq = r.irq;
    analog.powered = r.powered;
    analog.ref_internal = r.ref_act;
    analog.channel = r.chan_act;
    analog.sample = r.sample;
    analog.busy = r.busy;
  end

endmodule : sarcs_sequencer

// >>> inc/sarcs_pkg.sv
// Constants, register map and types for the conversion sequencer.
// Assumes a single 50 MHz core clock and an 8-bit plain register port.
//
// Overview of operation
// - Result split over low and high bytes, right or left justified.
// - Reading low byte locks results until high byte is read.
// - Complete flag still sets when a locked result is dropped.
// - Start bit begins a conversion, stays set, hardware clears it.
// - Channel change mid conversion applies only to the next one.
// - Reference and channel selections act only while enabled.
// - Auto trigger rising edge resets prescaler and starts a conversion.
// - Edges during conversion ignored; held level does not restart.
// - Trigger flags set regardless of enables; software clears them.
// - Complete flag as trigger gives free running, first by start bit.
// - Start bit reads one in any conversion; works under auto trigger.
// - Prescaler runs while enabled, held in reset while disabled.
// - Software start begins on next rising conversion clock edge.
// - Normal conversion 13 cycles, first after enable 25 cycles.
// - Sample at 1.5 cycles normally, 13.5 on first conversion.
// - Completion writes result, sets flag, clears start in single mode.
// - Auto triggered: sample two cycles in, three sync cycles, 13.5 total.
// - Free running restarts at completion, samples 2.5, lasts 14.
// - Reference bit picks supply or 1.1V; channel picks pin or internal.
// - Power reduction bit set keeps the converter inoperative.
// - Selections track writes, lock in conversion, free in last cycle.
package sarcs_pkg;

  // Register indices on the plain port
  localparam logic [2:0] REG_CTRL_A = 3'h0;
  localparam logic [2:0] REG_CTRL_B = 3'h1;
  localparam logic [2:0] REG_CHAN = 3'h2;
  localparam logic [2:0] REG_RES_LO = 3'h3;
  localparam logic [2:0] REG_RES_HI = 3'h4;
  localparam logic [2:0] REG_POWER = 3'h5;

  // Control A fields
  localparam int CA_ENABLE = 7;
  localparam int CA_START = 6;
  localparam int CA_AUTO = 5;
  localparam int CA_FLAG = 4;
  localparam int CA_IRQ_EN = 3;
  // Channel select register fields
  localparam int CH_REF = 6;
  localparam int CH_LEFT = 5;
  // Power register field
  localparam int PW_REDUCE = 0;

  // Channel codes of internal sources
  localparam logic [3:0] CHAN_TEMP = 4'h8;
  localparam logic [3:0] CHAN_BANDGAP = 4'hE;
  localparam logic [3:0] CHAN_GND = 4'hF;
  // Trigger code that selects the complete flag itself
  localparam logic [2:0] TRIG_FREE = 3'h0;

  // Core clock and recommended conversion clock band
  localparam int CORE_CLK_HZ = 50000000;
  localparam int CONV_CLK_MIN_HZ = 50000;
  localparam int CONV_CLK_MAX_HZ = 200000;

  // Conversion timing in half conversion-clock periods
  localparam logic [5:0] HALF_END_NORMAL = 6'h1A;  // 13
  localparam logic [5:0] HALF_END_FIRST = 6'h32;   // 25
  localparam logic [5:0] HALF_END_AUTO = 6'h1B;    // 13.5
  localparam logic [5:0] HALF_END_FREE = 6'h1C;    // 14
  localparam logic [5:0] HALF_SMP_NORMAL = 6'h03;  // 1.5
  localparam logic [5:0] HALF_SMP_FIRST = 6'h1B;   // 13.5
  localparam logic [5:0] HALF_SMP_AUTO = 6'h04;    // 2
  localparam logic [5:0] HALF_SMP_FREE = 6'h05;    // 2.5
  // Core cycles spent synchronising a trigger
  localparam logic [1:0] SYNC_CYCLES = 2'h3;

  typedef enum logic [1:0] {
    SARCS_ST_IDLE,
    SARCS_ST_SYNC,
    SARCS_ST_CONV
  } sarcs_state_t;

  typedef enum logic [1:0] {
    SARCS_K_NORMAL,
    SARCS_K_FIRST,
    SARCS_K_AUTO,
    SARCS_K_FREE
  } sarcs_kind_t;

  // Signals toward the analog multiplexer and comparator core
  typedef struct packed {
    logic powered;
    logic ref_internal;
    logic [3:0] channel;
    logic sample;
    logic busy;
  } sarcs_analog_t;

  // Register port request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sarcs_bus_t;

endpackage : sarcs_pkg

// >>> sim/sarcs_sequencer_chk.sv
// Port-level timing checks for the conversion sequencer.
// Assumes it is bound to the sequencer and sees only its ports.
module sarcs_sequencer_chk
  import sarcs_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire sarcs_pkg::sarcs_bus_t bus,
  input wire logic [7:0] rdata,
  input wire logic [7:0] trig_in,
  input wire logic [9:0] sar_result,
  input wire sarcs_pkg::sarcs_analog_t analog,
  input wire logic conv_irq
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  logic irq_en_q;

  // Mirror of the interrupt enable, since the flag itself is hidden
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      irq_en_q <= 1'b0;
    else if (bus.wr && bus.addr == REG_CTRL_A)
      irq_en_q <= bus.wdata[CA_IRQ_EN];
  end

  // Control A and power register accesses
  sequence s_rd_ctrl;
    bus.rd && bus.addr == REG_CTRL_A;
  endsequence
  sequence s_wr_off;
    bus.wr && bus.addr == REG_CTRL_A && !bus.wdata[CA_ENABLE];
  endsequence
  sequence s_wr_reduce;
    bus.wr && bus.addr == REG_POWER && bus.wdata[PW_REDUCE];
  endsequence

  a_start_reads_one: assert property (
    s_rd_ctrl ##0 analog.busy |=> rdata[CA_START])
    else $error("start bit low during conversion");
  a_sample_in_conv: assert property (
    analog.sample |-> analog.busy)
    else $error("sample outside conversion");
  a_sample_single: assert property (
    analog.sample |=> !analog.sample)
    else $error("sample pulse too long");
  a_busy_min_len: assert property (
    $rose(analog.busy) |-> analog.busy [*8])
    else $error("conversion too short");
  a_sel_locked: assert property (
    $rose(analog.busy) |=>
      $stable({analog.channel, analog.ref_internal}) [*4])
    else $error("selection moved early in conversion");
  a_disable_stops: assert property (
    s_wr_off |-> ##[1:2] (!analog.powered && !analog.busy))
    else $error("disable did not stop converter");
  a_reduce_stops: assert property (
    s_wr_reduce |-> ##[1:2] !analog.powered)
    else $error("power reduction ignored");
  a_off_no_conv: assert property (
    !analog.powered |=> !analog.busy)
    else $error("conversion while unpowered");
  a_done_irq: assert property (
    $fell(analog.busy) && analog.powered && irq_en_q |-> ##[0:1] conv_irq)
    else $error("completion raised no request");
endmodule : sarcs_sequencer_chk

bind sarcs_sequencer sarcs_sequencer_chk i_sarcs_sequencer_chk (
  .core_clk, .rst, .bus, .rdata, .trig_in, .sar_result, .analog, .conv_irq
);

// >>> sim/tb_sarcs_sequencer.sv
// Self-checking bench for the conversion sequencer.
// Assumes the package and checker are compiled before this file.
`define CHK(got, exp) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) \
    begin \
      num_errors++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end
module tb_sarcs_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  import sarcs_pkg::*;

  logic core_clk = 1'b0;
  logic rst = 1'b1;
  sarcs_bus_t bus = '0;
  logic [7:0] trig_in = 8'h00;
  logic [9:0] sar_result = 10'h000;
  logic [7:0] rdata;
  sarcs_analog_t analog;
  logic conv_irq;
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [7:0] d;
  int len;
  int smp;

  sarcs_sequencer i_sarcs_sequencer (
    .core_clk, .rst, .bus, .rdata, .trig_in, .sar_result, .analog, .conv_irq
  );

  // 50 MHz clock
  always #10 core_clk = ~core_clk;

  // Hang guard, far above the little over a thousand cycles needed
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge core_clk);
    bus.addr <= a;
    bus.wdata <= v;
    bus.wr <= 1'b1;
    @(posedge core_clk);
    bus.wr <= 1'b0;
  endtask : wr

  // Data is only valid in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge core_clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge core_clk);
    bus.rd <= 1'b0;
    #1;
    v = rdata;
  endtask : rd

  // Busy length and sample offset; both from the same edges
  task automatic conv(output int n, output int s);
    int w;
    w = 0;
    n = 0;
    s = -1;
    while (analog.busy !== 1'b1 && w < 300)
    begin
      tick(1);
      w++;
    end
    while (analog.busy === 1'b1 && n < 300)
    begin
      tick(1);
      n++;
      if (analog.sample === 1'b1)
        s = n;
    end
  endtask : conv

  task automatic next_smp(output int n);
    n = 0;
    do
    begin
      tick(1);
      n++;
    end
    while (analog.sample !== 1'b1 && n < 300);
  endtask : next_smp

  task automatic t_reset();
    for (int a = 0; a < 8; a++)
    begin
      rd(3'(a), d);
      `CHK(d, 8'h00)
    end
    `CHK(analog, '0)
  endtask : t_reset

  task automatic t_single();
    wr(REG_CHAN, 8'h43);
    tick(4);
    `CHK(analog.channel, 4'h0)
    // Fastest division for run time; real software picks 50 to 200 kHz
    wr(REG_CTRL_A, 8'h89);
    sar_result <= 10'h2A5;
    // Start is refused until the enable is already set
    wr(REG_CTRL_A, 8'hC9);
    conv(len, smp);
    `CHK(len, 50)
    `CHK(len - smp, 23)
    `CHK({analog.ref_internal, analog.channel}, 5'h13)
    `CHK(conv_irq, 1'b1)
    rd(REG_CTRL_A, d);
    `CHK(d, 8'h99)
    rd(REG_RES_LO, d);
    `CHK(d, 8'hA5)
    rd(REG_RES_HI, d);
    `CHK(d, 8'h02)
    wr(REG_CHAN, 8'h23);
    sar_result <= 10'h1C7;
    wr(REG_CTRL_A, 8'hD9);
    conv(len, smp);
    `CHK(len, 26)
    `CHK(len - smp, 23)
    rd(REG_RES_LO, d);
    `CHK(d, 8'hC0)
    rd(REG_RES_HI, d);
    `CHK(d, 8'h71)
    // Channel written mid conversion waits for the next one
    wr(REG_CTRL_A, 8'hD9);
    tick(6);
    wr(REG_CHAN, 8'h26);
    tick(2);
    `CHK(analog.channel, 4'h3)
    rd(REG_CTRL_A, d);
    `CHK(d[CA_START], 1'b1)
    conv(len, smp);
    `CHK(analog.channel, 4'h6)
  endtask : t_single

  task automatic t_lock();
    rd(REG_RES_LO, d);
    wr(REG_CTRL_A, 8'hD9);
    sar_result <= 10'h3FF;
    conv(len, smp);
    `CHK(conv_irq, 1'b1)
    rd(REG_RES_HI, d);
    `CHK(d, 8'h71)
    rd(REG_RES_LO, d);
    rd(REG_RES_HI, d);
    wr(REG_CTRL_A, 8'hD9);
    conv(len, smp);
    rd(REG_RES_LO, d);
    `CHK(d, 8'hC0)
    rd(REG_RES_HI, d);
    `CHK(d, 8'hFF)
  endtask : t_lock

  task automatic t_auto();
    wr(REG_CTRL_A, 8'hB1);
    for (int k = 1; k < 8; k++)
    begin
      wr(REG_CTRL_B, 8'(k));
      @(posedge core_clk);
      trig_in <= ~(8'h01 << k);
      tick(4);
      `CHK(analog.busy, 1'b0)
      @(posedge core_clk);
      trig_in <= 8'hFF;
      conv(len, smp);
      `CHK(len, 27)
      `CHK(len - smp, 23)
      tick(40);
      `CHK(analog.busy, 1'b0)
      @(posedge core_clk);
      trig_in <= 8'h00;
    end
    // A second edge inside a conversion must leave no restart behind
    @(posedge core_clk);
    trig_in <= 8'h80;
    repeat (8) @(posedge core_clk);
    trig_in <= 8'h00;
    repeat (2) @(posedge core_clk);
    trig_in <= 8'h80;
    conv(len, smp);
    tick(40);
    `CHK(analog.busy, 1'b0)
  endtask : t_auto

  task automatic t_free();
    wr(REG_CTRL_B, 8'h00);
    wr(REG_CTRL_A, 8'hF9);
    next_smp(len);
    next_smp(len);
    next_smp(len);
    `CHK(len, 28)
    next_smp(len);
    `CHK(len, 28)
    `CHK(conv_irq, 1'b1)
    rd(REG_CTRL_A, d);
    `CHK(d[CA_START], 1'b1)
    wr(REG_CTRL_A, 8'h00);
    tick(3);
    `CHK({analog.powered, analog.busy}, 2'h0)
  endtask : t_free

  task automatic t_power();
    wr(REG_POWER, 8'h01);
    wr(REG_CTRL_A, 8'hC9);
    tick(60);
    `CHK({analog.powered, analog.busy}, 2'h0)
    wr(REG_POWER, 8'h00);
    wr(REG_CTRL_A, 8'hC9);
    conv(len, smp);
    `CHK(len, 50)
  endtask : t_power

  // Main sequence
  initial
  begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_single();
    t_lock();
    t_auto();
    t_free();
    t_power();
    end_of_test();
  end
endmodule : tb_sarcs_sequencer
